// ---- include/line_ctrl_pkg.sv ----
/*
  Register map, field positions and reset values shared by the line
  transceiver control block and its helper modules.
  Assumes an 8-bit register file reached over a 32-bit classic Wishbone port.
*/
package line_ctrl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_LEVEL_INFO   = 8'h19;
  localparam logic [ADDR_W-1:0] IDX_FAULT_STATUS = 8'h1A;
  localparam logic [ADDR_W-1:0] IDX_FAULT_IRQ_EN = 8'h1B;
  localparam logic [ADDR_W-1:0] IDX_RX_MASTER    = 8'h20;
  localparam logic [ADDR_W-1:0] IDX_TX_MASTER    = 8'h21;
  localparam logic [ADDR_W-1:0] IDX_DS1_RX_CFG1  = 8'h22;
  // Live line fault info
  localparam logic [ADDR_W-1:0] IDX_LIVE_FAULT   = 8'h18;
  // Receive and transmit side sequencer states readback
  localparam logic [ADDR_W-1:0] IDX_SIDE_STATE   = 8'h30;

  localparam int unsigned WORD_LSB = 2;

  localparam logic [REG_W-1:0] RESET_ZERO = 8'h00;

  // Fault status and enable layout
  localparam int unsigned FLT_LOS    = 0;
  localparam int unsigned FLT_SHORT  = 1;
  localparam int unsigned FLT_OPEN   = 2;
  localparam int unsigned FLT_CLR_LSB = 4;
  localparam int unsigned FLT_N      = 3;
  localparam logic [REG_W-1:0] FLT_MASK = 8'h77;

  // Receive level field
  localparam int unsigned LVL_LSB = 4;
  localparam int unsigned LVL_W   = 4;

  // Master mode layout
  localparam int unsigned MM_ENABLE = 7;
  localparam int unsigned MM_INIT   = 6;
  localparam int unsigned MM_SRST   = 1;
  localparam int unsigned MM_E1     = 0;
  localparam logic [REG_W-1:0] MM_MASK = 8'hC3;

  // DS1 receive config layout
  localparam int unsigned CF_SYNC_TIME = 7;
  localparam int unsigned CF_B8ZS      = 6;
  localparam int unsigned CF_SF        = 5;
  localparam int unsigned CF_RESYNC    = 4;
  localparam int unsigned CF_SYNC_CRIT = 3;

  localparam logic [4:0] QUAL_SHORT = 5'h0A;
  localparam logic [4:0] QUAL_LONG  = 5'h18;

  typedef enum logic [1:0] {
    SIDE_OFF   = 2'b00,
    SIDE_RESET = 2'b01,
    SIDE_RUN   = 2'b11,
    SIDE_IDLE  = 2'b10
  } side_state_e;

endpackage : line_ctrl_pkg

// ---- hdl/fault_latch.sv ----
/*
  Latched edge status bits for the live line fault indicators, with
  write-one-to-clear and a set that wins over a clear.
  Assumes live indicators synchronous to clk_i.
*/
`timescale 1ns/10ps
module fault_latch
  import line_ctrl_pkg::*;
(
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic [line_ctrl_pkg::FLT_N-1:0] live_i,
  input  wire logic                            clear_i,
  input  wire logic [line_ctrl_pkg::REG_W-1:0] clear_mask_i,
  output logic      [line_ctrl_pkg::REG_W-1:0] status_o
);
  import line_ctrl_pkg::*;

  logic [FLT_N-1:0] live_d;
  logic [REG_W-1:0] next_status;

  genvar g;
  generate
    for (g = 0; g < FLT_N; g = g + 1)
    begin : g_bit
      wire rise = live_i[g] & ~live_d[g];
      wire fall = ~live_i[g] & live_d[g];
      wire clr_det = clear_i & clear_mask_i[g];
      wire clr_fal = clear_i & clear_mask_i[g+FLT_CLR_LSB];
      assign next_status[g] = rise | (status_o[g] & ~clr_det); // [R3] [R4] [R24]
      assign next_status[g+FLT_CLR_LSB] =
        fall | (status_o[g+FLT_CLR_LSB] & ~clr_fal); // [R2] [R4] [R24]
    end
  endgenerate

  assign next_status[3] = 1'b0;
  assign next_status[7] = 1'b0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      live_d   <= '0;
      status_o <= RESET_ZERO;
    end
    else
    begin
      live_d   <= live_i;
      status_o <= next_status;
    end
  end

endmodule : fault_latch

// ---- hdl/side_ctrl.sv ----
/*
  Enable sequencer for one side (receive framer or transmit formatter).
  Assumes mode bits come from a master mode register in the same domain.
*/
`timescale 1ns/10ps
module side_ctrl
  import line_ctrl_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 enable_i,
  input  wire logic                 init_done_i,
  input  wire logic                 soft_reset_i,
  output line_ctrl_pkg::side_state_e state_o
);
  import line_ctrl_pkg::*;

  side_state_e next_state;

  always_comb
  begin
    next_state = state_o;
    case (state_o)
      SIDE_OFF:   next_state = soft_reset_i ? SIDE_RESET :
                               (init_done_i & enable_i) ? SIDE_RUN : SIDE_OFF; // [R9] [R14]
      SIDE_RESET: next_state = soft_reset_i ? SIDE_RESET : SIDE_OFF; // [R10] [R15]
      SIDE_RUN:   next_state = soft_reset_i ? SIDE_RESET :
                               (~enable_i | ~init_done_i) ? SIDE_IDLE : SIDE_RUN; // [R7] [R12]
      SIDE_IDLE:  next_state = SIDE_OFF;
      default:    next_state = SIDE_OFF;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_o <= SIDE_OFF;
    else
      state_o <= next_state;
  end

endmodule : side_ctrl

// ---- hdl/line_ctrl.sv ----
/*
  Control and status registers of a timing-line transceiver: receive level,
  latched line faults with interrupt, master modes and DS1 receive config.
  Assumes a classic Wishbone master on the same clock; inputs synchronous.
*/
// How it works
// R1: Receive level field shows live amplitude code, 2.5 dB per step.
// R2: Clear-flags 6,5,4 latch when open, short, loss indicators fall.
// R3: Detect-flags 2,1,0 latch when open, short, loss indicators rise.
// R4: Writing one to a latched flag clears it; otherwise it holds.
// R5: Interrupt request is high when any flag and its enable are set.
// R6: Each enable bit masks its flag when zero, passes it when one.
// R7: Receive enable zero holds framer in low power; one activates it.
// R8: Host sets receive enable and line type before init-done.
// R9: After receive init-done, receive side runs only if enabled.
// R10: Receive soft reset holds framer in reset while one.
// R11: Receive line type bit selects T1 or E1 for receive only.
// R12: Transmit enable zero holds formatter in low power; one activates.
// R13: Host sets transmit enable and line type before init-done.
// R14: After transmit init-done, transmit side runs only if enabled.
// R15: Transmit soft reset holds formatter in reset while one.
// R16: Transmit line type bit selects T1 or E1 for transmit only.
// R17: Host leaves DS1 receive config alone while receive is E1.
// R18: Sync-time bit picks 10 or 24 qualified framing bits.
// R19: B8ZS decoding applies only when its enable bit is one.
// R20: Frame mode bit picks ESF at zero, SF at one.
// R21: Resync criteria: out-of-frame or loss at zero, out-of-frame only at one.
// R22: Sync criteria bit picks framing bit qualification per frame mode.
// R23: Live loss indicator follows line receiver and feeds latched flags.
// R24: Zero writes leave flags; an edge during a clear keeps it set.
`timescale 1ns/10ps
module line_ctrl
  import line_ctrl_pkg::*;
(
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             cyc_i,
  input  wire logic                             stb_i,
  input  wire logic                             we_i,
  input  wire logic [line_ctrl_pkg::ADDR_W+1:0] adr_i,
  input  wire logic [3:0]                       sel_i,
  input  wire logic [line_ctrl_pkg::DATA_W-1:0] dat_i,
  output logic      [line_ctrl_pkg::DATA_W-1:0] dat_o,
  output logic                                  ack_o,
  input  wire logic [line_ctrl_pkg::LVL_W-1:0]  rx_pulse_level_i,
  input  wire logic                             rx_signal_loss_i,
  input  wire logic                             tx_short_i,
  input  wire logic                             tx_open_i,
  output logic                                  irq_request_out_o,
  output logic                                  rx_framer_active_o,
  output logic                                  rx_framer_reset_o,
  output logic                                  rx_line_type_select_o,
  output logic                                  tx_formatter_active_o,
  output logic                                  tx_formatter_reset_o,
  output logic                                  tx_line_type_select_o,
  output logic      [4:0]                       sync_qualify_count_o,
  output logic                                  rx_zero_sub_decode_en_o,
  output logic                                  rx_frame_format_select_o,
  output logic                                  auto_resync_criteria_o,
  output logic                                  sync_criteria_select_o
);
  import line_ctrl_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [REG_W-1:0] irq_enable;
  logic [REG_W-1:0] rx_master;
  logic [REG_W-1:0] tx_master;
  logic [REG_W-1:0] ds1_cfg;
  logic [REG_W-1:0] fault_status;
  logic [REG_W-1:0] level_info;
  logic [REG_W-1:0] live_fault;
  side_state_e      rx_state;
  side_state_e      tx_state;

  wire              access     = cyc_i & stb_i & ~ack_o;
  wire              byte0      = sel_i[0];
  wire              wr         = access & we_i & byte0;
  wire [ADDR_W-1:0] idx        = adr_i[ADDR_W+WORD_LSB-1:WORD_LSB];
  wire              hit_status = idx == IDX_FAULT_STATUS;
  wire              hit_irq    = idx == IDX_FAULT_IRQ_EN;
  wire              hit_rxm    = idx == IDX_RX_MASTER;
  wire              hit_txm    = idx == IDX_TX_MASTER;
  wire              hit_cfg    = idx == IDX_DS1_RX_CFG1;
  wire              hit_level  = idx == IDX_LEVEL_INFO;
  wire              hit_live   = idx == IDX_LIVE_FAULT;
  wire              hit_side   = idx == IDX_SIDE_STATE;
  wire [REG_W-1:0]  wdata      = dat_i[REG_W-1:0];
  wire              clear_wr   = wr & hit_status; // [R4]

  wire [REG_W-1:0] side_view = {4'h0, tx_state, rx_state};

  wire [REG_W-1:0] rd_byte =
    hit_status ? fault_status :
    hit_irq    ? irq_enable   :
    hit_rxm    ? rx_master    :
    hit_txm    ? tx_master    :
    hit_cfg    ? ds1_cfg      :
    hit_level  ? level_info   :
    hit_live   ? live_fault   :
    hit_side   ? side_view    : RESET_ZERO;

  //////////////////////////////////////////////////////////////////////////
  // Write strobes

  wire wr_irq = wr & hit_irq;
  wire wr_rxm = wr & hit_rxm;
  wire wr_txm = wr & hit_txm;

  //////////////////////////////////////////////////////////////////////////
  // Live indicators and level

  assign level_info = {rx_pulse_level_i, 4'h0}; // [R1]
  wire [FLT_N-1:0] live_vec = {tx_open_i, tx_short_i, rx_signal_loss_i}; // [R23]
  assign live_fault = {5'h00, live_vec}; // [R23]

  //////////////////////////////////////////////////////////////////////////
  // Latched faults

  fault_latch u_fault (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .live_i       (live_vec),
    .clear_i      (clear_wr),
    .clear_mask_i (wdata),
    .status_o     (fault_status)
  );

  wire next_irq = |(fault_status & irq_enable); // [R5] [R6]

  //////////////////////////////////////////////////////////////////////////
  // Side sequencers

  side_ctrl u_rx (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .enable_i     (rx_master[MM_ENABLE]),
    .init_done_i  (rx_master[MM_INIT]),
    .soft_reset_i (rx_master[MM_SRST]),
    .state_o      (rx_state)
  );

  side_ctrl u_tx (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .enable_i     (tx_master[MM_ENABLE]),
    .init_done_i  (tx_master[MM_INIT]),
    .soft_reset_i (tx_master[MM_SRST]),
    .state_o      (tx_state)
  );

  // Config writes in E1 mode are the host's hazard; the register still stores
  wire cfg_wr = wr & hit_cfg; // [R17]

  wire [4:0] next_qual = ds1_cfg[CF_SYNC_TIME] ? QUAL_LONG : QUAL_SHORT; // [R18]

  //////////////////////////////////////////////////////////////////////////
  // Register next values

  wire [REG_W-1:0]  next_irq_enable = wdata & FLT_MASK;
  wire [REG_W-1:0]  next_rx_master  = wdata & MM_MASK;
  wire [REG_W-1:0]  next_tx_master  = wdata & MM_MASK;
  wire [REG_W-1:0]  next_ds1_cfg    = wdata;
  wire              next_ack        = access;
  wire [DATA_W-1:0] next_dat        = {{(DATA_W-REG_W){1'b0}}, rd_byte};

  //////////////////////////////////////////////////////////////////////////
  // Output next values

  wire next_rx_active = rx_state == SIDE_RUN; // [R7] [R9]
  wire next_rx_reset  = rx_master[MM_SRST]; // [R10]
  wire next_rx_type   = rx_master[MM_E1]; // [R11]
  wire next_tx_active = tx_state == SIDE_RUN; // [R12] [R14]
  wire next_tx_reset  = tx_master[MM_SRST]; // [R15]
  wire next_tx_type   = tx_master[MM_E1]; // [R16]
  wire next_zero_sub  = ds1_cfg[CF_B8ZS]; // [R19]
  wire next_frame_fmt = ds1_cfg[CF_SF]; // [R20]
  wire next_resync    = ds1_cfg[CF_RESYNC]; // [R21]
  wire next_sync_crit = ds1_cfg[CF_SYNC_CRIT]; // [R22]

  //////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_enable <= RESET_ZERO;
    else if (wr_irq)
      irq_enable <= next_irq_enable; // [R6]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_master <= RESET_ZERO;
    else if (wr_rxm)
      rx_master <= next_rx_master; // [R8]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_master <= RESET_ZERO;
    else if (wr_txm)
      tx_master <= next_tx_master; // [R13]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ds1_cfg <= RESET_ZERO;
    else if (cfg_wr)
      ds1_cfg <= next_ds1_cfg;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus answer

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= next_ack;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= '0;
    else
      dat_o <= next_dat;
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt output

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_request_out_o <= 1'b0;
    else
      irq_request_out_o <= next_irq; // [R5]
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive side outputs

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_framer_active_o <= 1'b0;
    else
      rx_framer_active_o <= next_rx_active; // [R7] [R9]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_framer_reset_o <= 1'b0;
    else
      rx_framer_reset_o <= next_rx_reset; // [R10]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_line_type_select_o <= 1'b0;
    else
      rx_line_type_select_o <= next_rx_type; // [R11]
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit side outputs

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_formatter_active_o <= 1'b0;
    else
      tx_formatter_active_o <= next_tx_active; // [R12] [R14]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_formatter_reset_o <= 1'b0;
    else
      tx_formatter_reset_o <= next_tx_reset; // [R15]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_line_type_select_o <= 1'b0;
    else
      tx_line_type_select_o <= next_tx_type; // [R16]
  end

  //////////////////////////////////////////////////////////////////////////
  // DS1 receive config outputs

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sync_qualify_count_o <= QUAL_SHORT;
    else
      sync_qualify_count_o <= next_qual; // [R18]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_zero_sub_decode_en_o <= 1'b0;
    else
      rx_zero_sub_decode_en_o <= next_zero_sub; // [R19]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_frame_format_select_o <= 1'b0;
    else
      rx_frame_format_select_o <= next_frame_fmt; // [R20]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      auto_resync_criteria_o <= 1'b0;
    else
      auto_resync_criteria_o <= next_resync; // [R21]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sync_criteria_select_o <= 1'b0;
    else
      sync_criteria_select_o <= next_sync_crit; // [R22]
  end

endmodule : line_ctrl

// ---- verification/line_ctrl_checker.sv ----
/* Port checker for line_ctrl.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module line_ctrl_checker
  import line_ctrl_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [3:0]  rx_pulse_level_i,
  input wire logic        irq_request_out_o,
  input wire logic        rx_framer_active_o,
  input wire logic        rx_framer_reset_o,
  input wire logic        rx_line_type_select_o,
  input wire logic        tx_formatter_active_o,
  input wire logic        tx_formatter_reset_o,
  input wire logic [4:0]  sync_qualify_count_o
);
  wire       take = cyc_i & stb_i & !ack_o;
  wire       wr   = take & we_i & sel_i[0];
  wire [7:0] ix   = adr_i[9:2];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  a_ack_follows: assert property (take |=> ack_o) else $error("ack missing");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_rdata_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper data");
  a_level_read: assert property (take && !we_i && ix == IDX_LEVEL_INFO
    |=> dat_o[7:4] == $past(rx_pulse_level_i)) else $error("level read");
  a_irq_masked: assert property (wr && ix == IDX_FAULT_IRQ_EN && dat_i[7:0] == 8'h00
    |-> ##[1:3] !irq_request_out_o) else $error("irq not masked");
  a_rx_reset_idle: assert property (rx_framer_reset_o [*3]
    |-> !rx_framer_active_o) else $error("rx active in reset");
  a_tx_reset_idle: assert property (tx_formatter_reset_o [*3]
    |-> !tx_formatter_active_o) else $error("tx active in reset");
  a_qual_long: assert property (wr && ix == IDX_DS1_RX_CFG1 && dat_i[CF_SYNC_TIME]
    |-> ##[1:3] sync_qualify_count_o == QUAL_LONG) else $error("sync count");
  a_rx_type_e1: assert property (wr && ix == IDX_RX_MASTER && dat_i[MM_E1]
    |-> ##[1:3] rx_line_type_select_o) else $error("rx line type");
  a_tx_off: assert property (wr && ix == IDX_TX_MASTER && !dat_i[MM_ENABLE]
    |-> ##[1:3] !tx_formatter_active_o) else $error("tx still active");
  cover property ($rose(irq_request_out_o));
  cover property ($rose(rx_framer_active_o));
  cover property ($rose(tx_formatter_active_o));
endmodule : line_ctrl_checker

bind line_ctrl line_ctrl_checker line_ctrl_checker_i (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .rx_pulse_level_i(rx_pulse_level_i),
  .irq_request_out_o(irq_request_out_o), .rx_framer_active_o(rx_framer_active_o),
  .rx_framer_reset_o(rx_framer_reset_o), .rx_line_type_select_o(rx_line_type_select_o),
  .tx_formatter_active_o(tx_formatter_active_o),
  .tx_formatter_reset_o(tx_formatter_reset_o), .sync_qualify_count_o(sync_qualify_count_o));

// ---- verification/line_host.sv ----
/* Host software model: classic Wishbone single cycles.
   Assumes a slave that acks every request. */
`timescale 1ns/10ps
module line_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [9:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  logic rx_e1 = 1'b0;
  initial
  begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  ////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    q = 8'h00;
    if (w && idx == 8'h22 && rx_e1) return;
    if (w && idx == 8'h20) rx_e1 = d[0];
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'b00};
    sel_o <= 4'h1;
    dat_o <= {24'h0, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = rdat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    adr_o <= ~{idx, 2'b00};
    dat_o <= ~{24'h0, d};
  endtask : xfer
endmodule : line_host

// ---- verification/line_ctrl_tb_top.sv ----
/* Self-checking bench for line_ctrl with host model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module line_ctrl_tb_top;
  import line_ctrl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, irq, rxa, rxr, rxt, txa, txr, txt, b8, sf, rsy, scr;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [4:0] qc;
  logic [3:0] lvl = 4'h0;
  logic [2:0] live = 3'h0;
  logic [7:0] q;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  initial forever #25 clk_i = ~clk_i;
  line_ctrl line_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .rx_pulse_level_i(lvl), .rx_signal_loss_i(live[0]), .tx_short_i(live[1]),
    .tx_open_i(live[2]), .irq_request_out_o(irq), .rx_framer_active_o(rxa),
    .rx_framer_reset_o(rxr), .rx_line_type_select_o(rxt), .tx_formatter_active_o(txa),
    .tx_formatter_reset_o(txr), .tx_line_type_select_o(txt), .sync_qualify_count_o(qc),
    .rx_zero_sub_decode_en_o(b8), .rx_frame_format_select_o(sf),
    .auto_resync_criteria_o(rsy), .sync_criteria_select_o(scr));
  line_host line_host_i (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    line_host_i.xfer(1'b1, idx, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    line_host_i.xfer(1'b0, idx, 8'h00, q);
    `CHK(q, exp)
  endtask : rd_chk
  task automatic t_reset;
    logic [7:0] ix [9] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h20, 8'h21, 8'h22, 8'h30, 8'h3F};
    `CHK(qc, QUAL_SHORT)
    foreach (ix[i]) rd_chk(ix[i], 8'h00);
    $display("reset values done");
  endtask : t_reset
  task automatic t_level;
    for (int c = 0; c < 16; c++)
    begin
      lvl <= c[3:0];
      repeat (2) @(posedge clk_i);
      rd_chk(IDX_LEVEL_INFO, {c[3:0], 4'h0});
    end
    $display("level done");
  endtask : t_level
  task automatic t_faults;
    for (int i = 0; i < 3; i++)
    begin
      live <= 3'(1 << i);
      repeat (4) @(posedge clk_i);
      rd_chk(IDX_FAULT_STATUS, 8'h01 << i);
      live <= 3'h0;
      repeat (4) @(posedge clk_i);
      rd_chk(IDX_FAULT_STATUS, (8'h01 << i) | (8'h10 << i));
      wr(IDX_FAULT_STATUS, 8'h00);
      rd_chk(IDX_FAULT_STATUS, (8'h01 << i) | (8'h10 << i));
      wr(IDX_FAULT_STATUS, 8'h01 << i);
      rd_chk(IDX_FAULT_STATUS, 8'h10 << i);
      wr(IDX_FAULT_STATUS, 8'h77);
      rd_chk(IDX_FAULT_STATUS, 8'h00);
    end
    live <= 3'h1;
    repeat (4) @(posedge clk_i);
    live <= 3'h0;
    repeat (4) @(posedge clk_i);
    fork
      wr(IDX_FAULT_STATUS, 8'h01);
      begin
        @(posedge clk_i);
        live <= 3'h1;
      end
    join
    rd_chk(IDX_FAULT_STATUS, 8'h11);
    live <= 3'h0;
    repeat (4) @(posedge clk_i);
    wr(IDX_FAULT_STATUS, 8'h77);
    rd_chk(IDX_FAULT_STATUS, 8'h00);
    $display("faults done");
  endtask : t_faults
  task automatic t_irq;
    logic [7:0] en [6] = '{8'h01, 8'h02, 8'h01, 8'h01, 8'h01, 8'h10};
    logic [7:0] cl [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    logic [2:0] lv [6] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0};
    logic       ex [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    foreach (en[k])
    begin
      wr(IDX_FAULT_IRQ_EN, en[k]);
      wr(IDX_FAULT_STATUS, cl[k]);
      live <= lv[k];
      repeat (5) @(posedge clk_i);
      `CHK(irq, ex[k])
    end
    wr(IDX_FAULT_STATUS, 8'h77);
    wr(IDX_FAULT_IRQ_EN, 8'h00);
    repeat (4) @(posedge clk_i);
    `CHK(irq, 1'b0)
    $display("irq done");
  endtask : t_irq
  task automatic t_side(input int s);
    logic [7:0] wv [7] = '{8'h80, 8'hC0, 8'hC2, 8'hC0, 8'h40, 8'h41, 8'h00};
    logic [2:0] ev [7] = '{3'b000, 3'b100, 3'b010, 3'b100, 3'b000, 3'b001, 3'b000};
    foreach (wv[k])
    begin
      wr(s ? IDX_TX_MASTER : IDX_RX_MASTER, wv[k]);
      repeat (3) @(posedge clk_i);
      `CHK(s ? {txa, txr, txt} : {rxa, rxr, rxt}, ev[k])
      `CHK(s ? rxt : txt, 1'b0)
    end
    $display("side %0d done", s);
  endtask : t_side
  task automatic t_cfg;
    wr(IDX_DS1_RX_CFG1, 8'hF8);
    repeat (3) @(posedge clk_i);
    `CHK({qc, b8, sf, rsy, scr}, {QUAL_LONG, 4'hF})
    rd_chk(IDX_DS1_RX_CFG1, 8'hF8);
    wr(IDX_DS1_RX_CFG1, 8'h50);
    repeat (3) @(posedge clk_i);
    `CHK({qc, b8, sf, rsy, scr}, {QUAL_SHORT, 4'hA})
    $display("config done");
  endtask : t_cfg
  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_level();
    t_faults();
    t_irq();
    t_side(0);
    t_side(1);
    t_cfg();
    final_report();
  end
endmodule : line_ctrl_tb_top
